// ---- core/dsl_load.sv ----
// Serial load port of a single-channel converter with its code register.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Each falling serial clock edge up to the 24th or 16th by variant shifts the data line into a 24 bit register.
// - The low-active frame select enables shifting, and only edges while it is low shift data.
// - The shifted word goes to the converter register after the 24th or 16th falling edge.
// - A frame select rise before the final edge aborts and the converter register keeps its value.
module dsl_load #(
    parameter bit WIDE = 1'b1
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        sclk,
    input  wire logic        frame_n,
    input  wire logic        din,
    output var  logic [15:0] analog_output,
    output var  logic        update
);

    // ********************************
    // Variant constants
    // ********************************
    localparam logic [4:0] LAST =
        5'(WIDE ? dsl_pkg::FRAME_BITS_WIDE : dsl_pkg::FRAME_BITS_NARROW);
    localparam int unsigned CODE_W =
        WIDE ? dsl_pkg::CODE_BITS_WIDE : dsl_pkg::CODE_BITS_NARROW;

    // ********************************
    // Helper functions
    // ********************************
    function automatic logic [23:0] shift_in(
        input logic [23:0] s,
        input logic        b
    );
        return {s[22:0], b};
    endfunction

    // Edges after the final one find the frame closed and are ignored.
    function automatic logic frame_open(
        input logic [4:0] c
    );
        return c != LAST;
    endfunction

    function automatic logic final_edge(
        input logic [4:0] c
    );
        return c == LAST - dsl_pkg::CNT_ONE;
    endfunction

    function automatic logic [4:0] next_count(
        input logic [4:0] c
    );
        return c + dsl_pkg::CNT_ONE;
    endfunction

    // The narrow variant keeps fourteen bits and pads the rest with zeros.
    function automatic logic [15:0] code_of(
        input logic [23:0] w
    );
        return 16'(w[CODE_W-1:0]);
    endfunction

    function automatic logic word_arrived(
        input logic t,
        input logic seen
    );
        return t != seen;
    endfunction

    // ********************************
    // Link domain on the falling serial clock
    // ********************************
    typedef struct packed {
        logic [23:0] shift;
        logic [4:0]  cnt;
        dsl_pkg::dsl_xfer_t xfer;
    } dsl_link_st_t;

    dsl_link_st_t lk_q;
    dsl_link_st_t lk_d;
    dsl_pkg::dsl_pins_t pins;
    logic lk_rst_n;

    assign pins.frame_n = frame_n;
    assign pins.data    = din;
    // The counter clears asynchronously on frame select high, so an early
    // rise discards the partial frame without needing a clock edge.
    assign lk_rst_n = resetn & ~pins.frame_n;

    // ********************************
    // Frame decode
    // ********************************
    logic frame_take;
    logic frame_last;
    assign frame_take = frame_open(lk_q.cnt);
    assign frame_last = final_edge(lk_q.cnt);

    // ********************************
    // Link next state
    // ********************************
    always_comb begin
        lk_d = lk_q;
        if (frame_take) begin
            lk_d.shift = shift_in(lk_q.shift, pins.data);
            lk_d.cnt   = next_count(lk_q.cnt);
        end
        // The finished word is captured before the toggle is seen in the
        // other domain, so it stands still while it is read there.
        if (frame_last) begin
            lk_d.xfer.word   = shift_in(lk_q.shift, pins.data);
            lk_d.xfer.toggle = ~lk_q.xfer.toggle;
        end
    end

    // ********************************
    // Link registers
    // ********************************
    logic [23:0] shift_q;
    logic [4:0]  cnt_q;
    always_ff @(negedge sclk or negedge lk_rst_n) begin
        if (!lk_rst_n) begin
            shift_q <= dsl_pkg::SHIFT_RST;
            cnt_q   <= dsl_pkg::CNT_RST;
        end else begin
            shift_q <= lk_d.shift;
            cnt_q   <= lk_d.cnt;
        end
    end

    // ********************************
    // Transfer register
    // ********************************
    // It survives frame select high, so only reset clears the last word.
    dsl_pkg::dsl_xfer_t xfer_q;
    always_ff @(negedge sclk or negedge resetn) begin
        if (!resetn) begin
            xfer_q <= '0;
        end else begin
            xfer_q <= lk_d.xfer;
        end
    end

    // ********************************
    // Link state view
    // ********************************
    always_comb begin
        lk_q.shift = shift_q;
        lk_q.cnt   = cnt_q;
        lk_q.xfer  = xfer_q;
    end

    // ********************************
    // Crossing into the system clock
    // ********************************
    // Only the toggle crosses through flip-flops; the word is held steady
    // until the next frame, which the host spaces far enough apart.
    logic tog_sync;

    dsl_sync u_sync (
        .clk   (ref_clk),
        .rst_n (resetn),
        .din   (xfer_q.toggle),
        .dout  (tog_sync)
    );

    // ********************************
    // System domain converter register
    // ********************************
    typedef struct packed {
        logic        tog_seen;
        logic [15:0] code;
        logic        upd;
    } dsl_sys_st_t;

    dsl_sys_st_t sy_q;
    dsl_sys_st_t sy_d;
    logic        new_word;

    assign new_word = word_arrived(tog_sync, sy_q.tog_seen);

    // ********************************
    // System next state
    // ********************************
    always_comb begin
        sy_d     = sy_q;
        sy_d.upd = 1'b0;
        if (new_word) begin
            // The word is stable: it changed on the same falling edge that flipped the toggle.
            sy_d.tog_seen = tog_sync;
            sy_d.code     = code_of(xfer_q.word);
            sy_d.upd      = 1'b1;
        end
    end

    // ********************************
    // System register
    // ********************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sy_q <= '0;
        end else begin
            sy_q <= sy_d;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign analog_output = sy_q.code;
    assign update        = sy_q.upd;

endmodule
`default_nettype wire

// ---- core/dsl_pkg.sv ----
// Package with the constants and carriers of the serial load interface.
package dsl_pkg;

    // ********************************
    // Frame lengths and data widths
    // ********************************
    localparam int unsigned FRAME_BITS_WIDE   = 24;
    localparam int unsigned FRAME_BITS_NARROW = 16;
    localparam int unsigned CODE_BITS_WIDE    = 16;
    localparam int unsigned CODE_BITS_NARROW  = 14;
    localparam int unsigned CNT_W             = 5;
    localparam int unsigned SHIFT_W           = 24;
    localparam logic [23:0] SHIFT_RST         = 24'h000000;
    localparam logic [4:0]  CNT_RST           = 5'h00;
    localparam logic [4:0]  CNT_ONE           = 5'h01;

    // ********************************
    // Host clock limit
    // ********************************
    localparam int unsigned SCLK_MAX_MHZ = 50;

    // ********************************
    // Carriers
    // ********************************
    typedef struct packed {
        logic frame_n;
        logic data;
    } dsl_pins_t;

    typedef struct packed {
        logic [23:0] word;
        logic        toggle;
    } dsl_xfer_t;

endpackage

// ---- core/dsl_sync.sv ----
// Two-stage synchroniser for a single level.
`timescale 1ns/1ps
`default_nettype none
module dsl_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output var  logic dout
);

    typedef struct packed {
        logic s1;
        logic s2;
    } dsl_sync_st_t;

    dsl_sync_st_t st_q;
    dsl_sync_st_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.s2;

endmodule
`default_nettype wire

// ---- test/dsl_host.sv ----
// Host model that writes frames into the serial load port.
`timescale 1ns/1ps
`default_nettype none
module dsl_host (
    output var logic sclk,
    output var logic frame_n,
    output var logic din
);
    initial begin
        sclk = 1'b1;
        frame_n = 1'b1;
        din = 1'b0;
    end
    task automatic send(input logic [23:0] w, input int n);
        #3 frame_n = 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            din = w[i];
            #80 sclk = 1'b0;
            #80 sclk = 1'b1;
        end
        din = ~din;
        frame_n = 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

// ---- test/dsl_load_properties.sv ----
// Checker with the timing properties of the serial load port.
`timescale 1ns/1ps
`default_nettype none
module dsl_load_properties (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        sclk,
    input wire logic        frame_n,
    input wire logic [15:0] analog_output,
    input wire logic        update
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence quiet_link;
        $stable(sclk) [*8];
    endsequence
    chk_quiet_no_update: assert property (quiet_link |-> !update)
        else $error("update without serial edge");
    chk_idle_no_update: assert property (frame_n [*8] |-> !update)
        else $error("update while deselected");
    chk_update_pulse: assert property (update |=> !update)
        else $error("update longer than one cycle");
    chk_code_hold: assert property ($changed(analog_output) |-> update)
        else $error("code changed without update");
endmodule
bind dsl_load dsl_load_properties chk (.ref_clk(ref_clk), .resetn(resetn),
    .sclk(sclk), .frame_n(frame_n), .analog_output(analog_output),
    .update(update));
`default_nettype wire

// ---- test/dsl_load_tb.sv ----
// Self-checking bench for the serial load port.
`timescale 1ns/1ps
`default_nettype none
module dsl_load_tb;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        sclk, frame_n, din, update;
    logic [15:0] analog_output;
    logic [15:0] analog_output_n;
    logic        update_n;
    int          n_upd_n = 0;
    int          mismatches = 0;
    int          num_checks = 0;
    int          n_upd = 0;
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (update === 1'b1) n_upd++;
    always @(posedge ref_clk) if (update_n === 1'b1) n_upd_n++;
    dsl_host host (.sclk(sclk), .frame_n(frame_n), .din(din));
    dsl_load #(.WIDE(1'b1)) uut (.ref_clk(ref_clk), .resetn(resetn),
        .sclk(sclk), .frame_n(frame_n), .din(din),
        .analog_output(analog_output), .update(update));
    dsl_load #(.WIDE(1'b0)) uut_n (.ref_clk(ref_clk), .resetn(resetn),
        .sclk(sclk), .frame_n(frame_n), .din(din),
        .analog_output(analog_output_n), .update(update_n));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("mismatches=%0d num_checks=%0d", mismatches, num_checks);
        if (mismatches == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic t_frame(input logic [23:0] w, input int n,
                           input logic [15:0] exp_u, input logic [15:0] exp,
                           input logic [15:0] exp_un, input logic [15:0] exp_n);
        int u;
        int un;
        u = n_upd;
        un = n_upd_n;
        host.send(w, n);
        repeat (8) @(posedge ref_clk);
        chk(16'(n_upd - u), exp_u);
        chk(analog_output, exp);
        chk(16'(n_upd_n - un), exp_un);
        chk(analog_output_n, exp_n);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (30) @(posedge ref_clk);
        chk(analog_output, 16'h0000);
        chk(analog_output_n, 16'h0000);
        t_frame(24'h00A5C3, 24, 16'h0001, 16'hA5C3,
                16'h0001, 16'h00A5);
        t_frame(24'hFFFFFF, 23, 16'h0000, 16'hA5C3,
                16'h0001, 16'h3FFF);
        t_frame(24'h3C5A96, 24, 16'h0001, 16'h5A96,
                16'h0001, 16'h3C5A);
        t_frame(24'h123456, 15, 16'h0000, 16'h5A96,
                16'h0000, 16'h3C5A);
        final_report();
    end
    initial begin
        #50000;
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
